// ### tlps_params.svh
// constants for the three-level pwm steering host controller
`ifndef TLPS_PARAMS_SVH
`define TLPS_PARAMS_SVH

// register byte offsets
`define TLPS_ADDR_CTRL        5'h00
`define TLPS_ADDR_PERIOD      5'h04
`define TLPS_ADDR_ON_TIME     5'h08
`define TLPS_ADDR_STATUS      5'h0C
`define TLPS_ADDR_PULSES      5'h10

// control field positions
`define TLPS_CTRL_RUN         0
`define TLPS_CTRL_DOUBLING    1
`define TLPS_CTRL_BYPASS      2
`define TLPS_CTRL_MID_RELEASE 3
`define TLPS_CTRL_MID_VOLTAGE 4
`define TLPS_CTRL_MID_ONLY    5
`define TLPS_CTRL_FORCE_MID   6
`define TLPS_CTRL_W           7

// status field positions
`define TLPS_STAT_READY       5
`define TLPS_STAT_CAL_TMO     6

// reset values
`define TLPS_CTRL_RST         7'h02
`define TLPS_PERIOD_RST       16'h0064
`define TLPS_ON_TIME_RST      16'h0020

// timing
`define TLPS_CLK_PERIOD_NS    100
`define TLPS_CLK_MHZ          10
`define TLPS_CAL_TIMEOUT_US   2000
`define TLPS_CAL_TIMEOUT_CYC  (`TLPS_CAL_TIMEOUT_US * `TLPS_CLK_MHZ)
`define TLPS_SHDN_MID_NS      1000
`define TLPS_SHDN_MID_CYC     ((`TLPS_SHDN_MID_NS + `TLPS_CLK_PERIOD_NS - 1) / `TLPS_CLK_PERIOD_NS)

`endif

// ### tlps_pkg.sv
// types for the three-level pwm steering host controller
package tlps_pkg;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		TLPS_OFF  = 5'h01,
		TLPS_CAL  = 5'h02,
		TLPS_ARM  = 5'h04,
		TLPS_RUN  = 5'h08,
		TLPS_SHDN = 5'h10
	} tlps_state_e;

	// three-level pwm code
	typedef enum logic [1:0] {
		TLPS_LOW  = 2'h0,
		TLPS_MID  = 2'h1,
		TLPS_HIGH = 2'h2
	} tlps_level_e;

endpackage

// ### tlps_host_ctrl.sv
// host controller that sequences and drives the three-level pwm phase steering device
`timescale 1ns/1ps
`include "tlps_params.svh"

module tlps_host_ctrl #(
	parameter int  CAL_TIMEOUT_CYC = `TLPS_CAL_TIMEOUT_CYC,
	parameter int  SHDN_MID_CYC    = `TLPS_SHDN_MID_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic [4:0]  addr,
	input  wire logic [31:0] wr_data,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic      [31:0] rd_data,
	input  wire logic        dev_ready,
	output logic             dev_enable,
	output logic             dev_driver_on,
	output logic      [1:0]  dev_pwm,
	output logic             doubling_select,
	output logic             bypass_select,
	output logic             mid_release_select,
	output logic             mid_voltage_select
);

	// register file state
	logic [`TLPS_CTRL_W-1:0] ctrl;
	logic [`TLPS_CTRL_W-1:0] next_ctrl;
	logic [15:0]             period;
	logic [15:0]             next_period;
	logic [15:0]             on_time;
	logic [15:0]             next_on_time;
	logic                    cal_tmo;
	logic                    next_cal_tmo;
	logic [31:0]             next_rd_data;

	// sequencer state
	tlps_pkg::tlps_state_e   state;
	tlps_pkg::tlps_state_e   next_state;
	logic [23:0]             wait_cnt;
	logic [23:0]             next_wait_cnt;
	logic                    next_dev_enable;
	logic                    next_dev_driver_on;
	logic                    cal_expired;

	// pwm generator state
	logic [15:0]             pwm_cnt;
	logic [15:0]             next_pwm_cnt;
	logic [1:0]              next_dev_pwm;
	logic [31:0]             pulses;
	logic [31:0]             next_pulses;

	// ready pin synchroniser
	logic                    ready_meta;
	logic                    ready_sync;

	// control bits
	logic                    run_req;
	logic                    mid_only;
	logic                    force_mid;

	assign run_req            = ctrl[`TLPS_CTRL_RUN];
	assign mid_only           = ctrl[`TLPS_CTRL_MID_ONLY];
	assign force_mid          = ctrl[`TLPS_CTRL_FORCE_MID];
	assign doubling_select    = ctrl[`TLPS_CTRL_DOUBLING];
	assign bypass_select      = ctrl[`TLPS_CTRL_BYPASS];
	assign mid_release_select = ctrl[`TLPS_CTRL_MID_RELEASE];
	assign mid_voltage_select = ctrl[`TLPS_CTRL_MID_VOLTAGE];
	assign cal_expired        = (wait_cnt == 24'(CAL_TIMEOUT_CYC - 1));

	// open-collector ready passes two flops
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ready_meta <= 1'b0;
			ready_sync <= 1'b0;
		end else begin
			ready_meta <= dev_ready;
			ready_sync <= ready_meta;
		end
	end

	// register writes, sticky timeout and read mux
	always_comb begin
		next_ctrl    = ctrl;
		next_period  = period;
		next_on_time = on_time;
		next_cal_tmo = cal_tmo;
		next_rd_data = 32'h00000000;
		if (wr_en) begin
			case (addr)
				`TLPS_ADDR_CTRL:    next_ctrl = wr_data[`TLPS_CTRL_W-1:0];
				`TLPS_ADDR_PERIOD:  next_period = wr_data[15:0];
				`TLPS_ADDR_ON_TIME: next_on_time = wr_data[15:0];
				`TLPS_ADDR_STATUS: begin
					if (wr_data[`TLPS_STAT_CAL_TMO]) begin
						next_cal_tmo = 1'b0;
					end
				end
				default: next_ctrl = ctrl;
			endcase
		end
		// a timeout in the clearing cycle still sets
		if (state == tlps_pkg::TLPS_CAL && cal_expired) begin
			next_cal_tmo = 1'b1;
		end
		if (rd_en) begin
			case (addr)
				`TLPS_ADDR_CTRL:    next_rd_data = {25'h0000000, ctrl};
				`TLPS_ADDR_PERIOD:  next_rd_data = {16'h0000, period};
				`TLPS_ADDR_ON_TIME: next_rd_data = {16'h0000, on_time};
				`TLPS_ADDR_STATUS:  next_rd_data = {25'h0000000, cal_tmo, ready_sync, state};
				`TLPS_ADDR_PULSES:  next_rd_data = pulses;
				default:            next_rd_data = 32'h00000000;
			endcase
		end
	end

	// register file flops
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl    <= `TLPS_CTRL_RST;
			period  <= `TLPS_PERIOD_RST;
			on_time <= `TLPS_ON_TIME_RST;
			cal_tmo <= 1'b0;
			rd_data <= 32'h00000000;
		end else begin
			ctrl    <= next_ctrl;
			period  <= next_period;
			on_time <= next_on_time;
			cal_tmo <= next_cal_tmo;
			rd_data <= next_rd_data;
		end
	end

	// enable and driver-on sequencing
	always_comb begin
		next_state         = state;
		next_wait_cnt      = wait_cnt;
		next_dev_enable    = dev_enable;
		next_dev_driver_on = dev_driver_on;
		case (state)
			tlps_pkg::TLPS_OFF: begin
				next_wait_cnt = 24'h000000;
				if (run_req) begin
					next_state         = tlps_pkg::TLPS_CAL;
					next_dev_enable    = 1'b1;
					next_dev_driver_on = 1'b0;
				end
			end
			tlps_pkg::TLPS_CAL: begin
				next_wait_cnt = wait_cnt + 24'h000001;
				if (!run_req || cal_expired) begin
					next_state         = tlps_pkg::TLPS_OFF;
					next_dev_enable    = 1'b0;
					next_dev_driver_on = 1'b0;
				end else if (ready_sync) begin
					next_state         = tlps_pkg::TLPS_ARM;
					next_dev_driver_on = 1'b1;
				end
			end
			tlps_pkg::TLPS_ARM: begin
				next_state = run_req ? tlps_pkg::TLPS_RUN : tlps_pkg::TLPS_SHDN;
				next_wait_cnt = 24'h000000;
			end
			tlps_pkg::TLPS_RUN: begin
				next_wait_cnt = 24'h000000;
				if (!run_req || !ready_sync) begin
					next_state = tlps_pkg::TLPS_SHDN;
				end
			end
			tlps_pkg::TLPS_SHDN: begin
				next_wait_cnt = wait_cnt + 24'h000001;
				if (wait_cnt >= 24'(SHDN_MID_CYC)) begin
					next_state         = tlps_pkg::TLPS_OFF;
					next_dev_enable    = 1'b0;
					next_dev_driver_on = 1'b0;
					next_wait_cnt      = 24'h000000;
				end
			end
			default: begin
				next_state         = tlps_pkg::TLPS_OFF;
				next_wait_cnt      = 24'h000000;
				next_dev_enable    = 1'b0;
				next_dev_driver_on = 1'b0;
			end
		endcase
	end

	// sequencer flops
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state         <= tlps_pkg::TLPS_OFF;
			wait_cnt      <= 24'h000000;
			dev_enable    <= 1'b0;
			dev_driver_on <= 1'b0;
		end else begin
			state         <= next_state;
			wait_cnt      <= next_wait_cnt;
			dev_enable    <= next_dev_enable;
			dev_driver_on <= next_dev_driver_on;
		end
	end

	// three-level pwm waveform and pulse counter
	always_comb begin
		next_pwm_cnt = 16'h0000;
		next_dev_pwm = tlps_pkg::TLPS_MID;
		next_pulses  = pulses;
		if (state == tlps_pkg::TLPS_RUN && !force_mid && run_req && ready_sync) begin
			next_pwm_cnt = (pwm_cnt + 16'h0001 >= period) ? 16'h0000 : pwm_cnt + 16'h0001;
			// high on time, then low or mid
			if (pwm_cnt < on_time) begin
				next_dev_pwm = tlps_pkg::TLPS_HIGH;
			end else begin
				// mid-only off level lets drivers run discontinuous
				next_dev_pwm = mid_only ? tlps_pkg::TLPS_MID : tlps_pkg::TLPS_LOW;
			end
		end
		// anything else parks the input at mid
		if (next_dev_pwm == tlps_pkg::TLPS_HIGH && dev_pwm != tlps_pkg::TLPS_HIGH) begin
			next_pulses = pulses + 32'h00000001;
		end
	end

	// pwm flops
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			pwm_cnt <= 16'h0000;
			dev_pwm <= tlps_pkg::TLPS_MID;
			pulses  <= 32'h00000000;
		end else begin
			pwm_cnt <= next_pwm_cnt;
			dev_pwm <= next_dev_pwm;
			pulses  <= next_pulses;
		end
	end

	// checks on what this controller drives
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	a_enable_pair_low: assert property (!(dev_driver_on && !dev_enable))
		else $error("driver-on high while enable low");

	// enable falls only with driver-on low
	a_shutdown_together: assert property ($fell(dev_enable) || $fell(dev_driver_on) |-> !dev_enable && !dev_driver_on)
		else $error("enable dropped without driver-on low");

	a_cal_driver_low: assert property (state == tlps_pkg::TLPS_CAL |-> dev_enable && !dev_driver_on)
		else $error("calibration phase without enable or with driver-on");

	a_no_early_pulse: assert property (dev_pwm == tlps_pkg::TLPS_HIGH |-> $past(state) == tlps_pkg::TLPS_RUN)
		else $error("pulse sent outside run");

	// ready in calibration arms then runs
	a_ready_to_run: assert property (state == tlps_pkg::TLPS_CAL && ready_sync && run_req && !cal_expired
		|=> state == tlps_pkg::TLPS_ARM && dev_driver_on ##1 state == tlps_pkg::TLPS_RUN || !run_req)
		else $error("ready did not lead to run");

	// force mid parks input next cycle
	a_force_mid: assert property (force_mid |=> dev_pwm == tlps_pkg::TLPS_MID)
		else $error("force mid not applied");

	a_mid_only_no_low: assert property (mid_only && $past(mid_only) |-> dev_pwm != tlps_pkg::TLPS_LOW)
		else $error("low driven in mid-only mode");

	a_shdn_mid: assert property (state == tlps_pkg::TLPS_SHDN && $past(state) == tlps_pkg::TLPS_SHDN
		|-> dev_pwm == tlps_pkg::TLPS_MID)
		else $error("pwm not mid during shutdown");

	a_pulse_count: assert property (dev_pwm == tlps_pkg::TLPS_HIGH && $past(dev_pwm) != tlps_pkg::TLPS_HIGH
		|-> pulses == $past(pulses) + 32'h00000001)
		else $error("pulse count missed a rise");

	a_cal_timeout: assert property (state == tlps_pkg::TLPS_CAL && cal_expired |=> cal_tmo && !dev_enable)
		else $error("calibration timeout not flagged");

endmodule

// ### tlps_dev_model.sv
// behavioural model of the three-level pwm phase steering device
`timescale 1ns/1ps
module tlps_dev_model #(
	parameter int CAL_NS = 1500
) (
	input  wire logic       enable,
	input  wire logic       driver_on,
	input  wire logic [1:0] pwm,
	input  wire logic       doubling,
	input  wire logic       bypass,
	input  wire logic       mid_release,
	input  wire logic       a_lower,
	input  wire logic       cal_stuck,
	output logic            ready,
	output logic      [1:0] pa,
	output logic      [1:0] pb,
	output logic            early
);
	localparam logic [1:0] LO = tlps_pkg::TLPS_LOW;
	localparam logic [1:0] MI = tlps_pkg::TLPS_MID;
	localparam logic [1:0] HI = tlps_pkg::TLPS_HIGH;
	logic       cal_done = 1'b0;
	logic       on_latch = 1'b0;
	logic       sel_a    = 1'b1;
	logic [1:0] prev     = 2'h1;
	wire        active   = cal_done && driver_on && (enable || on_latch);
	always @(posedge enable) begin
		cal_done = 1'b0;
		#(CAL_NS);
		cal_done = !cal_stuck;
	end
	// power down only with both low
	always @(enable, driver_on) begin
		if (enable && driver_on)
			on_latch = 1'b1;
		else if (!enable && !driver_on)
			on_latch = 1'b0;
	end
	assign ready = (enable || on_latch) && cal_done;
	initial early = 1'b0;
	always @(pwm, active, doubling, bypass) begin
		if (pwm == HI && !active)
			early = 1'b1;
		if (!active) begin
			pa = MI;
			pb = MI;
		end else if (bypass || !doubling) begin
			pa = pwm;
			pb = bypass ? pwm : MI;
		end else if (pwm == HI) begin
			if (prev != HI)
				sel_a = a_lower;
			if (sel_a)
				pa = HI;
			else
				pb = HI;
		end else if (pwm == LO) begin
			pa = LO;
			pb = LO;
		end else if (prev == HI && mid_release) begin
			if (sel_a)
				pa = MI;
			else
				pb = MI;
		end else begin
			pa = MI;
			pb = MI;
		end
		prev = pwm;
	end
endmodule

// ### tlps_host_ctrl_bench.sv
// self-checking bench for the three-level pwm steering host controller
`timescale 1ns/1ps
`include "tlps_params.svh"
module tlps_host_ctrl_bench;
	logic        clk_sys, rst_b, wr_en, rd_en, dev_ready, dev_enable, dev_driver_on;
	logic        dbl, byp, mrel, mvolt, a_lower, cal_stuck, early;
	logic [4:0]  addr;
	logic [31:0] wr_data, rd_data, v;
	logic [1:0]  dev_pwm, pha, phb;
	int          n_mismatch, checked, cyc, n, hi, lo;

	tlps_host_ctrl #(.CAL_TIMEOUT_CYC(50), .SHDN_MID_CYC(3)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.dev_ready(dev_ready), .dev_enable(dev_enable), .dev_driver_on(dev_driver_on), .dev_pwm(dev_pwm),
		.doubling_select(dbl), .bypass_select(byp), .mid_release_select(mrel), .mid_voltage_select(mvolt));
	tlps_dev_model dev (.enable(dev_enable), .driver_on(dev_driver_on), .pwm(dev_pwm), .doubling(dbl),
		.bypass(byp), .mid_release(mrel), .a_lower(a_lower), .cal_stuck(cal_stuck), .ready(dev_ready),
		.pa(pha), .pb(phb), .early(early));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// count high and low cycles of the pwm code
	task automatic count_pwm(input int cycles);
		hi = 0;
		lo = 0;
		repeat (cycles) begin
			@(posedge clk_sys);
			#1;
			if (dev_pwm === 2'h2)
				hi++;
			if (dev_pwm === 2'h0)
				lo++;
		end
	endtask
	task automatic wait_state(input logic [4:0] s);
		n = 0;
		do begin
			rd(`TLPS_ADDR_STATUS, v);
			n++;
		end while (v[4:0] !== s && n < 40);
		chk({27'h0, v[4:0]}, {27'h0, s});
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// cycle ceiling and current comparison stimulus
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		a_lower <= ~a_lower;
		if (cyc == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	initial begin
		{rst_b, wr_en, rd_en, cal_stuck, a_lower, addr, wr_data} = '0;
		{cyc, n_mismatch, checked} = '0;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(`TLPS_ADDR_CTRL, v);
		chk(v, 32'h02);
		chk({31'h0, dbl}, 32'h1);
		chk({30'h0, dev_pwm}, 32'h1);
		rd(`TLPS_ADDR_PERIOD, v);
		chk(v, 32'h64);
		rd(`TLPS_ADDR_ON_TIME, v);
		chk(v, 32'h20);
		wr(`TLPS_ADDR_PULSES, 32'h5);
		rd(`TLPS_ADDR_PULSES, v);
		chk(v, 32'h0);
		rd(5'h14, v);
		chk(v, 32'h0);
		wait_state(5'h01);
		$display("test reset done");
		wr(`TLPS_ADDR_PERIOD, 32'h8);
		wr(`TLPS_ADDR_ON_TIME, 32'h3);
		wr(`TLPS_ADDR_CTRL, 32'h1F);
		chk({28'h0, mvolt, mrel, byp, dbl}, 32'hF);
		wait_state(5'h08);
		count_pwm(16);
		chk(hi, 6);
		chk(lo, 10);
		$display("test startup done");
		wr(`TLPS_ADDR_CTRL, 32'h23);
		count_pwm(16);
		chk(hi, 6);
		chk(lo, 0);
		wr(`TLPS_ADDR_CTRL, 32'h43);
		repeat (2) @(posedge clk_sys);
		rd(`TLPS_ADDR_PULSES, v);
		n = v;
		chk({31'h0, v == 32'h0}, 32'h0);
		count_pwm(8);
		chk(hi + lo, 0);
		rd(`TLPS_ADDR_PULSES, v);
		chk(v, n);
		$display("test mid levels done");
		wr(`TLPS_ADDR_CTRL, 32'h02);
		n = 0;
		while (dev_enable === 1'b1 && n < 20) begin
			@(posedge clk_sys);
			#1;
			n++;
			chk({31'h0, dev_driver_on}, {31'h0, dev_enable});
		end
		wait_state(5'h01);
		$display("test shutdown done");
		cal_stuck <= 1'b1;
		wr(`TLPS_ADDR_CTRL, 32'h03);
		repeat (70) @(posedge clk_sys);
		rd(`TLPS_ADDR_STATUS, v);
		chk({31'h0, v[6]}, 32'h1);
		chk({31'h0, dev_driver_on}, 32'h0);
		wr(`TLPS_ADDR_CTRL, 32'h02);
		repeat (3) @(posedge clk_sys);
		wr(`TLPS_ADDR_STATUS, 32'h40);
		rd(`TLPS_ADDR_STATUS, v);
		chk(v, 32'h01);
		chk({31'h0, early}, 32'h0);
		$display("test calibration timeout done");
		report_and_stop();
	end
endmodule
